// *** src/pbqf_regs.vh ***
`ifndef PBQF_REGS_VH
`define PBQF_REGS_VH

// Section allocation field, control page 0
`define PBQF_ALLOC_PAGE      8'h00
`define PBQF_ALLOC_ADDR      7'h73
`define PBQF_ALLOC_MSB       3
`define PBQF_ALLOC_LSB       2
`define PBQF_ALLOC_RST       2'b10
`define PBQF_ALLOC_OFF       2'b00
`define PBQF_ALLOC_ONE       2'b01
`define PBQF_ALLOC_TWO       2'b10
`define PBQF_ALLOC_THREE     2'b11

// Coefficient pages and block layout
`define PBQF_COEF_PAGE_LO    8'h10
`define PBQF_COEF_PAGE_HI    8'h11
`define PBQF_COEF_BASE       7'h08
`define PBQF_SEC_BYTES       7'h14
`define PBQF_SECS_PER_PAGE   4'h6
`define PBQF_COEFS_PER_SEC   6'h05
`define PBQF_NUM_SECTIONS    12
`define PBQF_NUM_CHANNELS    4

// Coefficient order within a block
`define PBQF_IDX_N0          3'h0
`define PBQF_IDX_N1          3'h1
`define PBQF_IDX_N2          3'h2
`define PBQF_IDX_D1          3'h3
`define PBQF_IDX_D2          3'h4

// Reset coefficients: all-pass at unity gain
`define PBQF_N0_RST          32'h7fffffff
`define PBQF_COEF_RST        32'h00000000

// Leading denominator term is 2^31
`define PBQF_FRAC_SHIFT      31

`endif

// *** src/pbqf_coef_store.v ***
`timescale 1ns/1ps
`include "pbqf_regs.vh"

module pbqf_coef_store #(
  parameter NSEC  = 12,
  parameter NCOEF = 5
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        we,
  input  wire [5:0]  wr_idx,
  input  wire [1:0]  wr_byte,
  input  wire [7:0]  wr_data,
  input  wire [5:0]  rd_idx,
  output wire [31:0] rd_data
);

  localparam N = NSEC * NCOEF;

  wire [32*64-1:0] flat;

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_word
      if (g < N) begin : g_used
        localparam [5:0] IDX = g;
        localparam [31:0] RST_VAL = ((g % NCOEF) == 0) ? `PBQF_N0_RST : `PBQF_COEF_RST;
        reg [31:0] word_ff;
        always @(posedge clk) begin
          if (rst) begin
            word_ff <= RST_VAL;
          end else if (ce && we && wr_idx == IDX) begin
            // Most significant byte at the lowest address
            case (wr_byte)
              2'h0: word_ff[31:24] <= wr_data;
              2'h1: word_ff[23:16] <= wr_data;
              2'h2: word_ff[15:8] <= wr_data;
              default: word_ff[7:0] <= wr_data;
            endcase
          end
        end
        assign flat[g*32 +: 32] = word_ff;
      end else begin : g_unused
        assign flat[g*32 +: 32] = 32'h00000000;
      end
    end
  endgenerate

  assign rd_data = flat[{rd_idx, 5'h00} +: 32];

endmodule // pbqf_coef_store

// *** src/pbqf_mac.v ***
`timescale 1ns/1ps
`include "pbqf_regs.vh"

module pbqf_mac #(
  parameter DW = 32,
  parameter CW = 32
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          ce,
  input  wire          en,
  input  wire          load,
  input  wire          dbl,
  input  wire [CW-1:0] coef,
  input  wire [DW-1:0] data,
  output wire [DW-1:0] result
);

  localparam AW = CW + DW + 3;
  localparam SW = AW - `PBQF_FRAC_SHIFT;

  wire signed [CW+DW-1:0] prod = $signed(coef) * $signed(data);
  wire        [AW-1:0]    ext  = {{3{prod[CW+DW-1]}}, prod};
  // Doubled taps for the first-order numerator and denominator terms
  wire        [AW-1:0]    term = dbl ? {ext[AW-2:0], 1'b0} : ext;
  reg         [AW-1:0]    acc_ff;

  always @(posedge clk) begin
    if (rst) begin
      acc_ff <= {AW{1'b0}};
    end else if (ce && en) begin
      acc_ff <= load ? term : acc_ff + term;
    end
  end

  // Scale by 2^-31 and saturate to the sample width
  wire [SW-1:0] sh  = acc_ff[AW-1:`PBQF_FRAC_SHIFT];
  wire          ovf = (|sh[SW-1:DW-1]) & ~(&sh[SW-1:DW-1]);

  assign result = !ovf ? sh[DW-1:0] :
                  sh[SW-1] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};

endmodule // pbqf_mac

// *** src/pbqf_top.v ***
`timescale 1ns/1ps
`include "pbqf_regs.vh"

module pbqf_top #(
  parameter DW = 32
) (
  input  wire          CLK,
  input  wire          SYS_RST,
  input  wire          CE,
  input  wire          CFG_WE,
  input  wire [7:0]    CFG_PAGE,
  input  wire [6:0]    CFG_ADDR,
  input  wire [7:0]    CFG_WDATA,
  input  wire          TWO_CH_MODE,
  input  wire          BANK_SWITCH,
  input  wire          IN_VALID,
  input  wire [DW-1:0] IN_CH1,
  input  wire [DW-1:0] IN_CH2,
  input  wire [DW-1:0] IN_CH3,
  input  wire [DW-1:0] IN_CH4,
  output wire          IN_READY,
  output wire          OUT_VALID,
  output wire [DW-1:0] OUT_CH1,
  output wire [DW-1:0] OUT_CH2,
  output wire [DW-1:0] OUT_CH3,
  output wire [DW-1:0] OUT_CH4,
  output wire [1:0]    SECTION_ALLOC,
  output wire          ACTIVE_BANK
);

  localparam NSEC = `PBQF_NUM_SECTIONS;
  localparam NCH  = `PBQF_NUM_CHANNELS;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CHK  = 3'h1;
  localparam [2:0] ST_MAC  = 3'h2;
  localparam [2:0] ST_WB   = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;

  // Control port decode
  wire       alloc_hit  = CFG_WE && CFG_PAGE == `PBQF_ALLOC_PAGE && CFG_ADDR == `PBQF_ALLOC_ADDR;
  wire       page_lo    = CFG_PAGE == `PBQF_COEF_PAGE_LO;
  wire       page_hi    = CFG_PAGE == `PBQF_COEF_PAGE_HI;
  wire       addr_ok    = CFG_ADDR >= `PBQF_COEF_BASE;
  wire       coef_we    = CFG_WE && (page_lo || page_hi) && addr_ok;
  wire [6:0] wr_off     = CFG_ADDR - `PBQF_COEF_BASE;
  wire [6:0] wr_sec_pg  = wr_off / `PBQF_SEC_BYTES;
  wire [6:0] wr_rem     = wr_off - wr_sec_pg * `PBQF_SEC_BYTES;
  wire [3:0] wr_sec     = wr_sec_pg[3:0] + (page_hi ? `PBQF_SECS_PER_PAGE : 4'h0);
  wire [5:0] wr_idx     = {2'b00, wr_sec} * `PBQF_COEFS_PER_SEC + {1'b0, wr_rem[6:2]};

  reg [2:0]    state_ff;
  reg [1:0]    ch_ff;
  reg [1:0]    stg_ff;
  reg [2:0]    step_ff;
  reg [3:0]    sec_ff;
  reg [DW-1:0] cur_x_ff;
  reg [1:0]    alloc_ff;
  reg          bank_ff;
  reg          bank_use_ff;
  reg          two_ch_ff;
  reg          ready_ff;
  reg          valid_ff;
  reg [DW-1:0] smp_ff [0:NCH-1];
  reg [DW-1:0] out_ff [0:NCH-1];
  reg [DW-1:0] x1_ff  [0:NSEC-1];
  reg [DW-1:0] x2_ff  [0:NSEC-1];
  reg [DW-1:0] y1_ff  [0:NSEC-1];
  reg [DW-1:0] y2_ff  [0:NSEC-1];

  // Sections to run on the current channel
  wire       ch_bypass = alloc_ff == `PBQF_ALLOC_OFF || (two_ch_ff && ch_ff[1]);
  wire [1:0] nstg      = ch_bypass ? 2'b00 : alloc_ff;
  // In two-channel mode the second bank reuses the sections of channels 3 and 4
  wire [3:0] base_sec  = (two_ch_ff && bank_use_ff) ? {2'b00, ch_ff} + 4'h2 : {2'b00, ch_ff};
  // Section k serves channel ((k-1) mod 4)+1, stage by stage
  wire [3:0] nxt_sec   = base_sec + {stg_ff, 2'b00};

  wire [5:0]    rd_idx = {2'b00, sec_ff} * `PBQF_COEFS_PER_SEC + {3'h0, step_ff};
  wire [31:0]   coef;
  wire [DW-1:0] y_new;
  reg  [DW-1:0] mac_data;

  always @* begin
    case (step_ff)
      `PBQF_IDX_N0: mac_data = cur_x_ff;
      `PBQF_IDX_N1: mac_data = x1_ff[sec_ff];
      `PBQF_IDX_N2: mac_data = x2_ff[sec_ff];
      `PBQF_IDX_D1: mac_data = y1_ff[sec_ff];
      `PBQF_IDX_D2: mac_data = y2_ff[sec_ff];
      default:      mac_data = {DW{1'b0}};
    endcase
  end

  pbqf_coef_store #(
    .NSEC  (NSEC),
    .NCOEF (5)
  ) u_coef (
    .clk     (CLK),
    .rst     (SYS_RST),
    .ce      (CE),
    .we      (coef_we),
    .wr_idx  (wr_idx),
    .wr_byte (wr_rem[1:0]),
    .wr_data (CFG_WDATA),
    .rd_idx  (rd_idx),
    .rd_data (coef)
  );

  pbqf_mac #(
    .DW (DW),
    .CW (32)
  ) u_mac (
    .clk    (CLK),
    .rst    (SYS_RST),
    .ce     (CE),
    .en     (state_ff == ST_MAC),
    .load   (step_ff == `PBQF_IDX_N0),
    .dbl    (step_ff == `PBQF_IDX_N1 || step_ff == `PBQF_IDX_D1),
    .coef   (coef),
    .data   (mac_data),
    .result (y_new)
  );

  // Allocation field and bank switch
  always @(posedge CLK) begin
    if (SYS_RST) begin
      alloc_ff <= `PBQF_ALLOC_RST;
      bank_ff  <= 1'b0;
    end else if (CE) begin
      if (alloc_hit) begin
        alloc_ff <= CFG_WDATA[`PBQF_ALLOC_MSB:`PBQF_ALLOC_LSB];
      end
      if (BANK_SWITCH) begin
        bank_ff <= ~bank_ff;
      end
    end
  end

  // Per-section delay lines
  integer i;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      for (i = 0; i < NSEC; i = i + 1) begin
        x1_ff[i] <= {DW{1'b0}};
        x2_ff[i] <= {DW{1'b0}};
        y1_ff[i] <= {DW{1'b0}};
        y2_ff[i] <= {DW{1'b0}};
      end
    end else if (CE && state_ff == ST_WB) begin
      x2_ff[sec_ff] <= x1_ff[sec_ff];
      x1_ff[sec_ff] <= cur_x_ff;
      y2_ff[sec_ff] <= y1_ff[sec_ff];
      y1_ff[sec_ff] <= y_new;
    end
  end

  // Frame sequencer
  integer c;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state_ff    <= ST_IDLE;
      ch_ff       <= 2'h0;
      stg_ff      <= 2'h0;
      step_ff     <= 3'h0;
      sec_ff      <= 4'h0;
      cur_x_ff    <= {DW{1'b0}};
      bank_use_ff <= 1'b0;
      two_ch_ff   <= 1'b0;
      ready_ff    <= 1'b0;
      valid_ff    <= 1'b0;
      for (c = 0; c < NCH; c = c + 1) begin
        smp_ff[c] <= {DW{1'b0}};
        out_ff[c] <= {DW{1'b0}};
      end
    end else if (CE) begin
      valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          ready_ff <= 1'b1;
          if (IN_VALID && ready_ff) begin
            smp_ff[0]   <= IN_CH1;
            smp_ff[1]   <= IN_CH2;
            smp_ff[2]   <= IN_CH3;
            smp_ff[3]   <= IN_CH4;
            cur_x_ff    <= IN_CH1;
            ch_ff       <= 2'h0;
            stg_ff      <= 2'h0;
            // Bank and mode are held for the whole frame
            bank_use_ff <= bank_ff;
            two_ch_ff   <= TWO_CH_MODE;
            ready_ff    <= 1'b0;
            state_ff    <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (stg_ff < nstg) begin
            sec_ff   <= nxt_sec;
            step_ff  <= `PBQF_IDX_N0;
            state_ff <= ST_MAC;
          end else begin
            smp_ff[ch_ff] <= cur_x_ff;
            if (ch_ff == 2'h3) begin
              state_ff <= ST_DONE;
            end else begin
              ch_ff    <= ch_ff + 2'h1;
              stg_ff   <= 2'h0;
              cur_x_ff <= smp_ff[ch_ff + 2'h1];
            end
          end
        end
        ST_MAC: begin
          if (step_ff == `PBQF_IDX_D2) begin
            state_ff <= ST_WB;
          end else begin
            step_ff <= step_ff + 3'h1;
          end
        end
        ST_WB: begin
          // Cascade: this stage's output feeds the next
          cur_x_ff <= y_new;
          stg_ff   <= stg_ff + 2'h1;
          step_ff  <= `PBQF_IDX_N0;
          state_ff <= ST_CHK;
        end
        ST_DONE: begin
          for (c = 0; c < NCH; c = c + 1) begin
            out_ff[c] <= smp_ff[c];
          end
          valid_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign IN_READY      = ready_ff;
  assign OUT_VALID     = valid_ff;
  assign OUT_CH1       = out_ff[0];
  assign OUT_CH2       = out_ff[1];
  assign OUT_CH3       = out_ff[2];
  assign OUT_CH4       = out_ff[3];
  assign SECTION_ALLOC = alloc_ff;
  assign ACTIVE_BANK   = bank_ff;

endmodule // pbqf_top

// *** tb/pbqf_chk.sv ***
`timescale 1ns/1ps
`include "pbqf_regs.vh"
module pbqf_chk #(
  parameter DW = 32
) (
  input wire          CLK,
  input wire          SYS_RST,
  input wire          CE,
  input wire          CFG_WE,
  input wire [7:0]    CFG_PAGE,
  input wire [6:0]    CFG_ADDR,
  input wire [7:0]    CFG_WDATA,
  input wire          TWO_CH_MODE,
  input wire          BANK_SWITCH,
  input wire          IN_VALID,
  input wire [DW-1:0] IN_CH1,
  input wire          IN_READY,
  input wire          OUT_VALID,
  input wire [DW-1:0] OUT_CH1,
  input wire [1:0]    SECTION_ALLOC,
  input wire          ACTIVE_BANK
);
  wire       take = CE && IN_VALID && IN_READY && !TWO_CH_MODE;
  wire       awr  = CE && CFG_WE && CFG_PAGE == `PBQF_ALLOC_PAGE && CFG_ADDR == `PBQF_ALLOC_ADDR;
  wire [1:0] wsel = CFG_WDATA[`PBQF_ALLOC_MSB:`PBQF_ALLOC_LSB];
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  AST_RST_VALUES: assert property (disable iff (1'b0) SYS_RST |=>
    SECTION_ALLOC == `PBQF_ALLOC_RST && !IN_READY && !OUT_VALID && !ACTIVE_BANK) else $error("bad reset state");
  AST_ALLOC_WRITE: assert property (awr |=> SECTION_ALLOC == $past(wsel))
    else $error("allocation write lost");
  AST_ALLOC_HOLD: assert property (!awr |=> $stable(SECTION_ALLOC))
    else $error("allocation changed without write");
  AST_BANK_FLIP: assert property (CE && BANK_SWITCH |=> ACTIVE_BANK != $past(ACTIVE_BANK))
    else $error("bank did not toggle");
  AST_BANK_HOLD: assert property (!BANK_SWITCH |=> $stable(ACTIVE_BANK))
    else $error("bank changed without switch");
  AST_BYPASS: assert property (take && SECTION_ALLOC == `PBQF_ALLOC_OFF |->
    ##6 OUT_VALID && OUT_CH1 == $past(IN_CH1, 6)) else $error("bypass frame wrong");
  AST_ONE_LAT: assert property (take && SECTION_ALLOC == `PBQF_ALLOC_ONE |-> ##34 OUT_VALID)
    else $error("one-section latency wrong");
  AST_TWO_LAT: assert property (take && SECTION_ALLOC == `PBQF_ALLOC_TWO |-> ##62 OUT_VALID)
    else $error("two-section latency wrong");
  AST_THREE_LAT: assert property (take && SECTION_ALLOC == `PBQF_ALLOC_THREE |-> ##90 OUT_VALID)
    else $error("three-section latency wrong");
  cover property (take && SECTION_ALLOC == `PBQF_ALLOC_THREE);
  cover property (CE && BANK_SWITCH);
  cover property (OUT_VALID);
endmodule // pbqf_chk

bind pbqf_top pbqf_chk #(.DW(DW)) pbqf_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .CFG_WE(CFG_WE),
  .CFG_PAGE(CFG_PAGE), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA), .TWO_CH_MODE(TWO_CH_MODE),
  .BANK_SWITCH(BANK_SWITCH), .IN_VALID(IN_VALID), .IN_CH1(IN_CH1), .IN_READY(IN_READY),
  .OUT_VALID(OUT_VALID), .OUT_CH1(OUT_CH1), .SECTION_ALLOC(SECTION_ALLOC), .ACTIVE_BANK(ACTIVE_BANK));

// *** tb/pbqf_host.sv ***
`timescale 1ns/1ps
module pbqf_host (
  input  wire       clk,
  output reg        cfg_we,
  output reg  [7:0] cfg_page,
  output reg  [6:0] cfg_addr,
  output reg  [7:0] cfg_wdata
);
  initial begin
    cfg_we = 1'b0;
    cfg_page = 8'h00;
    cfg_addr = 7'h00;
    cfg_wdata = 8'h00;
  end
  task wr(input [7:0] pg, input [6:0] ad, input [7:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_page <= pg;
    cfg_addr <= ad;
    cfg_wdata <= d;
  endtask
  // Released data lines do not keep the last byte
  task done;
    @(posedge clk);
    cfg_we <= 1'b0;
    cfg_wdata <= ~cfg_wdata;
  endtask
  // Caller finishes all loads before streaming frames
  task coef(input [3:0] sec, input [2:0] idx, input [31:0] v);
    integer b;
    for (b = 0; b < 4; b = b + 1) begin
      wr((sec < 6) ? 8'h10 : 8'h11, 7'(8 + 20 * (sec % 6) + 4 * idx + b), v[31 - 8 * b -: 8]);
    end
    done;
  endtask
endmodule // pbqf_host

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "pbqf_regs.vh"
module testbench;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         two_ch = 1'b0;
  reg         bank_sw = 1'b0;
  reg         ce = 1'b1;
  reg         in_valid = 1'b0;
  reg  [31:0] in_ch [1:4];
  wire [31:0] out_ch [1:4];
  wire        we, rdy, o_valid, act_bank;
  wire [7:0]  pg, wd;
  wire [6:0]  ad;
  wire [1:0]  alloc;
  integer     error_cnt = 0;
  integer     n_checks = 0;
  integer     k;
  always #20 clk = ~clk;
  pbqf_host pbqf_host_i (.clk(clk), .cfg_we(we), .cfg_page(pg), .cfg_addr(ad), .cfg_wdata(wd));
  pbqf_top pbqf_top_i (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .CFG_WE(we), .CFG_PAGE(pg), .CFG_ADDR(ad),
    .CFG_WDATA(wd), .TWO_CH_MODE(two_ch), .BANK_SWITCH(bank_sw), .IN_VALID(in_valid), .IN_CH1(in_ch[1]),
    .IN_CH2(in_ch[2]), .IN_CH3(in_ch[3]), .IN_CH4(in_ch[4]), .IN_READY(rdy), .OUT_VALID(o_valid),
    .OUT_CH1(out_ch[1]), .OUT_CH2(out_ch[2]), .OUT_CH3(out_ch[3]), .OUT_CH4(out_ch[4]),
    .SECTION_ALLOC(alloc), .ACTIVE_BANK(act_bank));
  task check(input [31:0] got, input [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task set_alloc(input [7:0] d);
    pbqf_host_i.wr(8'h00, 7'h73, d);
    pbqf_host_i.done;
    @(negedge clk);
  endtask
  // Sends base*k on channel k and times the answer
  task frame(input [31:0] base, input integer lat);
    integer n;
    n = 0;
    while (rdy !== 1'b1 && n < 300) begin
      @(negedge clk);
      n = n + 1;
    end
    if (n >= 300) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
    @(posedge clk);
    in_valid <= 1'b1;
    for (n = 1; n < 5; n = n + 1) begin
      in_ch[n] <= base * n;
    end
    @(posedge clk);
    in_valid <= 1'b0;
    n = 0;
    while (o_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n = n + 1;
    end
    check(n, lat);
    if (n >= 300) report_and_stop;
  endtask
  initial begin
    for (k = 1; k < 5; k = k + 1) in_ch[k] = 32'h0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(alloc, `PBQF_ALLOC_RST);
    check({rdy, o_valid, act_bank}, 3'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    // Default sections: floor(x*(2^31-1)/2^31) = x-1, two per channel
    frame(32'h1000, 62);
    for (k = 1; k < 5; k = k + 1) check(out_ch[k], k * 32'h1000 - 2);
    set_alloc(8'hf3);
    check(alloc, `PBQF_ALLOC_OFF);
    frame(32'h1000, 6);
    for (k = 1; k < 5; k = k + 1) check(out_ch[k], k * 32'h1000);
    pbqf_host_i.coef(4'h0, `PBQF_IDX_N0, 32'h40000000);
    set_alloc(8'h04);
    frame(32'h1000, 34);
    check(out_ch[1], 32'h800);
    for (k = 2; k < 5; k = k + 1) check(out_ch[k], k * 32'h1000 - 1);
    pbqf_host_i.coef(4'h8, `PBQF_IDX_N0, 32'h40000000);
    set_alloc(8'h0c);
    frame(32'h1000, 90);
    check(out_ch[1], 32'h3ff);
    for (k = 2; k < 5; k = k + 1) check(out_ch[k], k * 32'h1000 - 3);
    // Section 2 as a pure one-sample delay: 2*N1 = 2^31
    pbqf_host_i.coef(4'h1, `PBQF_IDX_N0, 32'h0);
    pbqf_host_i.coef(4'h1, `PBQF_IDX_N1, 32'h40000000);
    set_alloc(8'h04);
    frame(32'h5000, 34);
    check(out_ch[2], 32'h2000);
    frame(32'h1000, 34);
    check(out_ch[2], 32'ha000);
    // Switch pulse while frozen is ignored
    @(posedge clk);
    ce <= 1'b0;
    bank_sw <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    bank_sw <= 1'b0;
    @(negedge clk);
    check(act_bank, 1'b0);
    @(posedge clk);
    two_ch <= 1'b1;
    bank_sw <= 1'b1;
    @(posedge clk);
    bank_sw <= 1'b0;
    @(negedge clk);
    check(act_bank, 1'b1);
    frame(32'h1000, 20);
    check(out_ch[1], 32'h0fff);
    check(out_ch[2], 32'h1fff);
    check(out_ch[3], 32'h3000);
    check(out_ch[4], 32'h4000);
    // Back to the first bank: own sections again, ch3/ch4 still unfiltered
    @(posedge clk);
    bank_sw <= 1'b1;
    @(posedge clk);
    bank_sw <= 1'b0;
    @(negedge clk);
    check(act_bank, 1'b0);
    frame(32'h1000, 20);
    check(out_ch[1], 32'h0800);
    check(out_ch[2], 32'h2000);
    check(out_ch[3], 32'h3000);
    check(out_ch[4], 32'h4000);
    report_and_stop;
  end
endmodule // testbench
